// File: inc/pmss_pkg.sv
// package: register map, field layout, modes and timing of the supervisor
package pmss_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_WAKE_EN = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_CAUSE = 4'hc;
  localparam int TRIP_W = 4;
  localparam logic [TRIP_W-1:0] TRIP_MAX = 4'he;
  localparam logic [TRIP_W-1:0] TRIP_RST = 4'h0;
  localparam int CTRL_REDUCED = 0;
  localparam int CTRL_HIB_REQ = 1;
  localparam int CTRL_WARN_EN = 2;
  localparam int CTRL_TRIP_LO = 4;
  localparam int WEN_CMP = 0;
  localparam int WEN_RTC = 1;
  localparam int CAUSE_W = 4;
  localparam int CAUSE_UV = 0;
  localparam int CAUSE_OV = 1;
  localparam int CAUSE_HIB = 2;
  localparam int CAUSE_WARN = 3;
  localparam int RST_PULSE_CYC = 8;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;

  typedef enum logic [1:0] {
    PMSS_CPU_ACTIVE = 2'b00,
    PMSS_CPU_SLEEP = 2'b01,
    PMSS_CPU_DEEP = 2'b11
  } pmss_cpu_t;

  typedef enum logic [1:0] {
    PMSS_SYS_RUN = 2'b00,
    PMSS_SYS_DEEP = 2'b01,
    PMSS_SYS_HIB = 2'b11,
    PMSS_SYS_RESET = 2'b10
  } pmss_sys_t;

  // per-cpu sleep request from the core
  typedef struct packed {
    logic wait_exec;
    logic deep_sel;
    logic irq;
  } pmss_core_req_t;

  // domain enables to the clock and power fabric
  typedef struct packed {
    logic hf_clk_en;
    logic hs_periph_en;
    logic lf_periph_en;
    logic gpio_freeze;
    logic cmp_en;
    logic core_reduced;
  } pmss_power_t;
endpackage

// File: rtl/pmss_supervisor.sv
// supply supervisor and system power mode sequencer
`timescale 1ns/1ps
// Behaviour
// - undervoltage detect forces system reset before supply minimum is reached
// - undervoltage detector is hardware only, no register affects it
// - supply below selected trip level raises the warning interrupt
// - trip level field selects one of 15 levels
// - warning inactive and silent in system deep sleep or hibernate
// - overvoltage on digital or core supply forces reset, no enable
// - wait with deep select clear puts that cpu to sleep
// - wait with deep select set puts that cpu in deep sleep
// - any interrupt to a cpu returns it to active
// - system deep sleep only when both cpus deep; high clocks off
// - deep sleep keeps low clock and low-power wakeup peripherals alive
// - deep sleep wakeup returns to the mode it was entered from
// - hibernate freezes gpio, only comparator and backup stay on
// - wake pin, reset pin or enabled comparator leaves hibernate via reset
// - watchdog also wakes from hibernate
// - rtc alarm wakes from deep sleep, and from hibernate when enabled
// - normal power mode is primary, full voltage and full clock
// - reduced voltage mode lowers core voltage and limits clocks
module pmss_supervisor
  import pmss_pkg::*;
#(
  parameter int NCPU = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pmss_core_req_t [NCPU-1:0] core_req,
  output pmss_cpu_t [NCPU-1:0] cpu_state,
  input wire logic undervoltage_reset_detector,
  input wire logic overvoltage_digital_supply,
  input wire logic overvoltage_core_supply,
  input wire logic [TRIP_MAX:0] supply_warning_detector,
  input wire logic external_reset_pin_n,
  input wire logic wakeup_pin,
  input wire logic lp_cmp_event,
  input wire logic watchdog_wake,
  input wire logic rtc_alarm,
  input wire logic lp_periph_irq,
  output logic system_reset_n,
  output logic supply_warning_irq,
  output logic [TRIP_W-1:0] trip_select,
  output pmss_power_t power_ctrl,
  output pmss_sys_t sys_state
);
  localparam int NPIN = 9;
  localparam int CW = $clog2(RST_PULSE_CYC + 1);
  localparam logic [CW-1:0] RST_LEN = CW'(RST_PULSE_CYC);
  // domain enables in run at normal power; also the value held in reset
  localparam pmss_power_t PWR_RUN = '{
    hf_clk_en: 1'b1,
    hs_periph_en: 1'b1,
    lf_periph_en: 1'b1,
    gpio_freeze: 1'b0,
    cmp_en: 1'b1,
    core_reduced: 1'b0
  };

  // clear-on-write-one with set priority
  function automatic logic sticky(input logic cur, input logic set,
                                  input logic clr);
    sticky = set | (cur & ~clr);
  endfunction

  // write strobe for one register, lane zero carries every field
  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
                                  input logic [3:0] be,
                                  input logic [ADDR_W-1:0] off);
    wr_hit = wr && a == off && be[0];
  endfunction

  // pin side synchronised copies
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  logic uv_s, ovd_s, ovc_s, external_reset_pin_s, wpin_s, cmp_s, wdt_s, rtc_s, lpi_s;
  logic [TRIP_MAX:0] warn_s;

  // reset pin enters inverted: the chain clears to zero, which must mean
  // released, or every power-up would be followed by a false reset pulse
  assign pin_raw = {undervoltage_reset_detector, overvoltage_digital_supply,
                    overvoltage_core_supply, ~external_reset_pin_n,
                    wakeup_pin, lp_cmp_event, watchdog_wake, rtc_alarm,
                    lp_periph_irq};
  assign {uv_s, ovd_s, ovc_s, external_reset_pin_s, wpin_s, cmp_s, wdt_s, rtc_s,
          lpi_s} = pin_s;

  pmss_sync #(.WIDTH(NPIN)) u_sync_pins (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(pin_raw),
    .pin_out(pin_s)
  );

  pmss_sync #(.WIDTH(int'(TRIP_MAX) + 1)) u_sync_warn (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pin_in(supply_warning_detector),
    .pin_out(warn_s)
  );

  // registers
  logic reduced_q, reduced_d;
  logic warn_en_q, warn_en_d;
  logic [TRIP_W-1:0] trip_q, trip_d;
  logic [1:0] wen_q, wen_d;
  logic [CAUSE_W-1:0] cause_q, cause_d;
  logic warn_flag_q, warn_flag_d;
  logic resumed_reduced_q, resumed_reduced_d;
  pmss_sys_t sys_q, sys_d;
  pmss_cpu_t [NCPU-1:0] cpu_q, cpu_d;
  logic [CW-1:0] rcnt_q, rcnt_d;
  logic [31:0] rdata_q, rdata_d;
  logic hib_req_q, hib_req_d;
  logic rd_pend_q, rd_pend_d;
  logic reduced_nx;

  // bus decode; writes land on the edge they are seen, reads stall one
  // cycle so that registered read data stand when waitrequest drops
  logic wr_ctrl, wr_wen, wr_cause;
  logic rd_take;
  logic [31:0] ctrl_rd, status_rd, wen_rd, cause_rd;
  logic [31:0] rd_mux;
  assign rd_take = avs_read && !rd_pend_q;
  assign rd_pend_d = rd_take;
  assign avs_waitrequest = rd_take; // one wait state per read
  assign wr_ctrl = wr_hit(avs_write, avs_address, avs_byteenable, OFF_CTRL);
  assign wr_wen = wr_hit(avs_write, avs_address, avs_byteenable,
                         OFF_WAKE_EN);
  assign wr_cause = wr_hit(avs_write, avs_address, avs_byteenable,
                           OFF_CAUSE);
  // register images as software reads them
  assign ctrl_rd = {24'h0, trip_q, 1'b0, warn_en_q, hib_req_q, reduced_q};
  assign status_rd = {22'h0, cpu_q[1], cpu_q[0], sys_q, 1'b0, warn_flag_q,
                      2'b0};
  assign wen_rd = {30'h0, wen_q};
  assign cause_rd = {28'h0, cause_q};
  assign rd_mux = (avs_address == OFF_CTRL) ? ctrl_rd :
                  (avs_address == OFF_STATUS) ? status_rd :
                  (avs_address == OFF_WAKE_EN) ? wen_rd :
                  (avs_address == OFF_CAUSE) ? cause_rd : ZERO32;
  // capture on the stalled cycle, hold until the next read
  assign rdata_d = rd_take ? rd_mux : rdata_q;
  assign avs_readdata = rdata_q;

  // supply faults: reset from undervoltage or overvoltage, no register
  logic supply_fault;
  assign supply_fault = uv_s | ovd_s | ovc_s;

  // hibernate wake sources, all end in a full reset
  logic hib_wake;
  assign hib_wake = wpin_s | external_reset_pin_s | (cmp_s & wen_q[WEN_CMP])
                    | wdt_s
                    | (rtc_s & wen_q[WEN_RTC]);

  // deep sleep wakeup from low-power peripherals, comparator, watchdog, rtc, wake pin
  logic deep_wake;
  assign deep_wake = lpi_s | cmp_s | wdt_s | rtc_s | wpin_s;

  // warning compare, gated off outside run
  logic warn_hit;
  logic warn_live;
  assign warn_live = warn_en_q && sys_q == PMSS_SYS_RUN;
  assign warn_hit = warn_live && warn_s[trip_q];

  // control writes; trip field clipped to the 15 legal levels
  logic [TRIP_W-1:0] trip_wr;
  assign trip_wr = avs_writedata[CTRL_TRIP_LO +: TRIP_W];
  assign trip_d = wr_ctrl ? ((trip_wr > TRIP_MAX) ? TRIP_MAX : trip_wr)
                          : trip_q;
  assign warn_en_d = wr_ctrl ? avs_writedata[CTRL_WARN_EN] : warn_en_q;
  assign hib_req_d = sys_d == PMSS_SYS_RUN
                     && (wr_ctrl ? avs_writedata[CTRL_HIB_REQ]
                                 : hib_req_q);
  assign wen_d = wr_wen ? {avs_writedata[WEN_RTC], avs_writedata[WEN_CMP]}
                        : wen_q;
  assign warn_flag_d = sticky(warn_flag_q, warn_hit,
    wr_cause && avs_writedata[CAUSE_WARN]);

  // mode register changes by software write in run, is restored on deep sleep exit and clears on reset
  always_comb begin
    reduced_d = reduced_q;
    resumed_reduced_d = resumed_reduced_q;
    if (wr_ctrl && sys_q == PMSS_SYS_RUN) begin
      reduced_d = avs_writedata[CTRL_REDUCED];
    end
    if (sys_q == PMSS_SYS_RUN) begin
      resumed_reduced_d = reduced_q;
    end
    if (sys_q == PMSS_SYS_DEEP && sys_d == PMSS_SYS_RUN) begin
      reduced_d = resumed_reduced_q;
    end
  end

  // all cpus in deep sleep at once
  logic all_deep;
  always_comb begin
    all_deep = 1'b1;
    for (int i = 0; i < NCPU; i++) begin
      all_deep = all_deep & (cpu_q[i] == PMSS_CPU_DEEP);
    end
  end

  // system mode sequencer
  always_comb begin
    sys_d = sys_q;
    rcnt_d = rcnt_q;
    case (sys_q)
      PMSS_SYS_RUN: begin
        if (hib_req_q) begin
          sys_d = PMSS_SYS_HIB;
        end else if (all_deep && !deep_wake) begin
          sys_d = PMSS_SYS_DEEP;
        end
      end
      PMSS_SYS_DEEP: begin
        if (deep_wake) begin
          sys_d = PMSS_SYS_RUN;
        end
      end
      PMSS_SYS_HIB: begin
        if (hib_wake) begin
          sys_d = PMSS_SYS_RESET;
          rcnt_d = RST_LEN;
        end
      end
      PMSS_SYS_RESET: begin
        if (rcnt_q == '0) begin
          sys_d = PMSS_SYS_RUN;
        end else begin
          rcnt_d = rcnt_q - CW'(1);
        end
      end
      default: sys_d = PMSS_SYS_RESET;
    endcase
    // a supply fault or the reset pin beats every state and reloads the
    // hold count, so the reset pulse always outlasts its cause
    if (supply_fault || external_reset_pin_s) begin
      sys_d = PMSS_SYS_RESET;
      rcnt_d = RST_LEN;
    end
  end

  // cause flags, set wins over a software clear
  assign cause_d = {
    sticky(cause_q[CAUSE_WARN], warn_hit,
           wr_cause && avs_writedata[CAUSE_WARN]),
    sticky(cause_q[CAUSE_HIB], sys_q == PMSS_SYS_HIB && hib_wake,
           wr_cause && avs_writedata[CAUSE_HIB]),
    sticky(cause_q[CAUSE_OV], ovd_s | ovc_s,
           wr_cause && avs_writedata[CAUSE_OV]),
    sticky(cause_q[CAUSE_UV], uv_s,
           wr_cause && avs_writedata[CAUSE_UV])};

  // per-cpu sleep state
  always_comb begin
    for (int i = 0; i < NCPU; i++) begin
      cpu_d[i] = cpu_q[i];
      if (sys_q != PMSS_SYS_RUN && sys_q != PMSS_SYS_DEEP) begin
        cpu_d[i] = PMSS_CPU_ACTIVE;
      end else if (core_req[i].irq
                   || (sys_q == PMSS_SYS_DEEP && deep_wake)) begin
        cpu_d[i] = PMSS_CPU_ACTIVE;
      end else if (cpu_q[i] == PMSS_CPU_ACTIVE && core_req[i].wait_exec) begin
        cpu_d[i] = core_req[i].deep_sel ? PMSS_CPU_DEEP
                                        : PMSS_CPU_SLEEP;
      end
    end
  end

  // outputs toward the power fabric
  pmss_power_t pwr_d, pwr_q;
  assign pwr_d.hf_clk_en = sys_d == PMSS_SYS_RUN;
  assign pwr_d.hs_periph_en = sys_d == PMSS_SYS_RUN;
  assign pwr_d.lf_periph_en = sys_d == PMSS_SYS_RUN
                              || sys_d == PMSS_SYS_DEEP;
  assign pwr_d.gpio_freeze = sys_d == PMSS_SYS_HIB;
  assign pwr_d.cmp_en = 1'b1;
  // a reset always lands at full voltage, so the mode bit and the
  // regulator select clear on the same edge
  assign reduced_nx = (sys_d == PMSS_SYS_RESET) ? 1'b0 : reduced_d;
  assign pwr_d.core_reduced = reduced_nx;

  assign cpu_state = cpu_q;
  assign sys_state = sys_q;
  assign power_ctrl = pwr_q;
  assign trip_select = trip_q;
  assign supply_warning_irq = warn_flag_q;
  assign system_reset_n = sys_q != PMSS_SYS_RESET;

  // state flops, reset lands in run at normal power
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_q <= PMSS_SYS_RUN;
      cpu_q <= {NCPU{PMSS_CPU_ACTIVE}};
      reduced_q <= 1'b0;
      resumed_reduced_q <= 1'b0;
      rcnt_q <= '0;
      pwr_q <= PWR_RUN;
    end else begin
      sys_q <= sys_d;
      cpu_q <= cpu_d;
      reduced_q <= reduced_nx;
      resumed_reduced_q <= resumed_reduced_d;
      rcnt_q <= rcnt_d;
      pwr_q <= pwr_d;
    end
  end

  // software-visible registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_en_q <= 1'b0;
      trip_q <= TRIP_RST;
      wen_q <= '0;
      cause_q <= '0;
      warn_flag_q <= 1'b0;
      hib_req_q <= 1'b0;
      rdata_q <= ZERO32;
      rd_pend_q <= 1'b0;
    end else begin
      warn_en_q <= warn_en_d;
      trip_q <= trip_d;
      wen_q <= wen_d;
      cause_q <= cause_d;
      warn_flag_q <= warn_flag_d;
      hib_req_q <= hib_req_d;
      rdata_q <= rdata_d;
      rd_pend_q <= rd_pend_d;
    end
  end
endmodule

// File: rtl/pmss_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pmss_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;
  logic [WIDTH-1:0] out_d;

  // change taken only when stages two and three agree
  assign out_d = (s2_q & s3_q) | (out_q & (s2_q | s3_q));
  assign pin_out = out_q;

  // shift chain
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end
endmodule

// File: sim/pmss_core_model.sv
// model of the two cores issuing wait and interrupt requests
`timescale 1ns/1ps
module pmss_core_model
  import pmss_pkg::*;
(
  input wire pmss_cpu_t [1:0] cpu_state,
  input wire logic [1:0] go_wait,
  input wire logic [1:0] go_deep,
  input wire logic [1:0] go_irq,
  output pmss_core_req_t [1:0] core_req
);
  // a halted core executes no further wait instruction
  for (genvar i = 0; i < 2; i++) begin : g_cpu
    assign core_req[i].wait_exec = go_wait[i] &&
      cpu_state[i] == PMSS_CPU_ACTIVE;
    assign core_req[i].deep_sel = go_deep[i];
    assign core_req[i].irq = go_irq[i];
  end
endmodule

// File: sim/pmss_supervisor_props.sv
// assertions on the supervisor ports
`timescale 1ns/1ps
module pmss_supervisor_props
  import pmss_pkg::*;
#(
  parameter int NCPU = 2
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire pmss_core_req_t [NCPU-1:0] core_req,
  input wire pmss_cpu_t [NCPU-1:0] cpu_state,
  input wire logic undervoltage_reset_detector,
  input wire logic overvoltage_digital_supply,
  input wire logic overvoltage_core_supply,
  input wire logic system_reset_n,
  input wire logic supply_warning_irq,
  input wire logic [TRIP_W-1:0] trip_select,
  input wire pmss_power_t power_ctrl,
  input wire pmss_sys_t sys_state
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // supply faults reach the reset output within the filter delay; trip level stays in range
  uv_reset_a: assert property (
    undervoltage_reset_detector |-> ##[1:10] !system_reset_n)
    else $error("no reset on undervoltage");
  ov_reset_a: assert property (
    overvoltage_digital_supply || overvoltage_core_supply
    |-> ##[1:10] !system_reset_n)
    else $error("no reset on overvoltage");
  trip_range_a: assert property (trip_select <= TRIP_MAX)
    else $error("trip level out of range");
  // warning only starts while running
  warn_quiet_a: assert property (
    $rose(supply_warning_irq) |-> $past(sys_state) == PMSS_SYS_RUN)
    else $error("warning raised while asleep");
  // cpu0 sleep entry and interrupt wake, deep sleep entry guard, deep sleep and hibernate domains
  sleep_entry_a: assert property (
    sys_state == PMSS_SYS_RUN && cpu_state[0] == PMSS_CPU_ACTIVE &&
    core_req[0].wait_exec && !core_req[0].deep_sel && !core_req[0].irq
    |-> ##[1:2] cpu_state[0] == PMSS_CPU_SLEEP)
    else $error("cpu0 did not sleep");
  irq_wake_a: assert property (
    sys_state == PMSS_SYS_RUN && cpu_state[0] != PMSS_CPU_ACTIVE &&
    core_req[0].irq |-> ##[1:2] cpu_state[0] == PMSS_CPU_ACTIVE)
    else $error("cpu0 not woken");
  deep_guard_a: assert property (
    sys_state == PMSS_SYS_RUN && !(cpu_state[0] == PMSS_CPU_DEEP &&
    cpu_state[1] == PMSS_CPU_DEEP) |=> sys_state != PMSS_SYS_DEEP)
    else $error("deep sleep without both cpus");
  deep_power_a: assert property (
    sys_state == PMSS_SYS_DEEP ##1 sys_state == PMSS_SYS_DEEP
    |-> !power_ctrl.hf_clk_en && power_ctrl.lf_periph_en)
    else $error("deep sleep domains wrong");
  hib_power_a: assert property (
    sys_state == PMSS_SYS_HIB ##1 sys_state == PMSS_SYS_HIB
    |-> power_ctrl.gpio_freeze && power_ctrl.cmp_en &&
    !power_ctrl.hf_clk_en)
    else $error("hibernate domains wrong");
endmodule
bind pmss_supervisor pmss_supervisor_props #(.NCPU(NCPU)) i_props (
  .ref_clk(ref_clk),
  .rst_n(rst_n),
  .core_req(core_req),
  .cpu_state(cpu_state),
  .undervoltage_reset_detector(undervoltage_reset_detector),
  .overvoltage_digital_supply(overvoltage_digital_supply),
  .overvoltage_core_supply(overvoltage_core_supply),
  .system_reset_n(system_reset_n),
  .supply_warning_irq(supply_warning_irq),
  .trip_select(trip_select),
  .power_ctrl(power_ctrl),
  .sys_state(sys_state)
);

// File: sim/testbench.sv
// self-checking bench of the supervisor
`timescale 1ns/1ps
module testbench;
  import pmss_pkg::*;
  logic ref_clk = 0;
  logic rst_n = 0;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [31:0] avs_writedata = '0, avs_readdata, rv;
  logic [3:0] avs_byteenable = 4'hf;
  pmss_core_req_t [1:0] core_req;
  pmss_cpu_t [1:0] cpu_state;
  logic [1:0] go_wait = 0, go_deep = 0, go_irq = 0;
  logic undervoltage_reset_detector = 0, overvoltage_digital_supply = 0;
  logic overvoltage_core_supply = 0, wakeup_pin = 0, lp_cmp_event = 0;
  logic watchdog_wake = 0, rtc_alarm = 0, lp_periph_irq = 0;
  logic external_reset_pin_n = 1, system_reset_n, supply_warning_irq;
  logic [TRIP_MAX:0] supply_warning_detector = '0;
  logic [TRIP_W-1:0] trip_select;
  pmss_power_t power_ctrl;
  pmss_sys_t sys_state;
  int n_errors = 0, tests_run = 0;
  pmss_supervisor i_pmss_supervisor (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .core_req(core_req),
    .cpu_state(cpu_state),
    .undervoltage_reset_detector(undervoltage_reset_detector),
    .overvoltage_digital_supply(overvoltage_digital_supply),
    .overvoltage_core_supply(overvoltage_core_supply),
    .supply_warning_detector(supply_warning_detector),
    .external_reset_pin_n(external_reset_pin_n),
    .wakeup_pin(wakeup_pin),
    .lp_cmp_event(lp_cmp_event),
    .watchdog_wake(watchdog_wake),
    .rtc_alarm(rtc_alarm),
    .lp_periph_irq(lp_periph_irq),
    .system_reset_n(system_reset_n),
    .supply_warning_irq(supply_warning_irq),
    .trip_select(trip_select),
    .power_ctrl(power_ctrl),
    .sys_state(sys_state)
  );
  pmss_core_model i_pmss_core_model (
    .cpu_state(cpu_state),
    .go_wait(go_wait),
    .go_deep(go_deep),
    .go_irq(go_irq),
    .core_req(core_req)
  );
  // clock at 200 MHz
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge; read
  // data taken at that same edge, then one idle edge lets results settle
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest) @(posedge ref_clk);
    rv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_sys(input pmss_sys_t s);
    int i;
    i = 0;
    while (sys_state !== s && i < 60) begin
      @(posedge ref_clk);
      i++;
    end
    chk(32'(sys_state), 32'(s));
  endtask
  task automatic core(input logic [1:0] w, d, q);
    @(posedge ref_clk);
    go_wait <= w;
    go_deep <= d;
    go_irq <= q;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic t_modes;
    chk(32'(power_ctrl), 32'h3a);
    bus(1, OFF_CTRL, 32'h1);
    chk(32'(power_ctrl.core_reduced), 32'h1);
    bus(0, OFF_CTRL, '0);
    chk(rv, 32'h1);
    bus(0, 4'h2, '0);
    chk(rv, 32'h0);
  endtask
  task automatic t_cpu;
    core(2'b01, 2'b00, 2'b00);
    chk(32'(cpu_state[0]), 32'(PMSS_CPU_SLEEP));
    bus(0, OFF_STATUS, '0);
    chk(rv, 32'h40);
    core(2'b00, 2'b00, 2'b01);
    chk(32'(cpu_state[0]), 32'(PMSS_CPU_ACTIVE));
    core(2'b01, 2'b01, 2'b00);
    chk(32'(cpu_state), 32'(PMSS_CPU_DEEP));
    core(2'b00, 2'b00, 2'b01);
    core(2'b00, 2'b00, 2'b00);
  endtask
  task automatic t_deep;
    bus(1, OFF_CTRL, 32'h35);
    core(2'b11, 2'b11, 2'b00);
    wait_sys(PMSS_SYS_DEEP);
    core(2'b00, 2'b00, 2'b00);
    chk(32'({power_ctrl.hf_clk_en, power_ctrl.lf_periph_en}), 1);
    supply_warning_detector <= '1;
    repeat (10) @(posedge ref_clk);
    chk(32'(supply_warning_irq), 0);
    supply_warning_detector <= '0;
    repeat (10) @(posedge ref_clk);
    lp_periph_irq <= 1'b1;
    wait_sys(PMSS_SYS_RUN);
    lp_periph_irq <= 1'b0;
    chk(32'({cpu_state, power_ctrl.core_reduced}), 1);
  endtask
  task automatic t_warn;
    supply_warning_detector <= 15'h0004;
    repeat (10) @(posedge ref_clk);
    chk(32'(supply_warning_irq), 0);
    supply_warning_detector <= 15'h0008;
    repeat (10) @(posedge ref_clk);
    chk(32'(supply_warning_irq), 1);
    supply_warning_detector <= '0;
    repeat (8) @(posedge ref_clk);
    bus(1, OFF_CAUSE, 32'h8);
    chk(32'(supply_warning_irq), 0);
    bus(1, OFF_CTRL, 32'hf4);
    chk(32'(trip_select), 32'(TRIP_MAX));
  endtask
  task automatic t_fault;
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      {overvoltage_core_supply, overvoltage_digital_supply,
       undervoltage_reset_detector} <= 3'(1 << k);
      repeat (12) @(posedge ref_clk);
      chk(32'(system_reset_n), 0);
      {overvoltage_core_supply, overvoltage_digital_supply,
       undervoltage_reset_detector} <= 3'h0;
      wait_sys(PMSS_SYS_RUN);
      chk(32'(power_ctrl), 32'h3a);
    end
  endtask
  // every hibernate wake source, reset pin last
  task automatic t_hib;
    for (int k = 0; k < 5; k++) begin
      bus(1, OFF_WAKE_EN, 32'h3);
      bus(1, OFF_CTRL, 32'h2);
      wait_sys(PMSS_SYS_HIB);
      @(posedge ref_clk);
      chk(32'({power_ctrl.hf_clk_en, power_ctrl.gpio_freeze,
               power_ctrl.cmp_en}), 3);
      {external_reset_pin_n, lp_cmp_event, rtc_alarm, watchdog_wake,
       wakeup_pin} <= 5'h10 ^ 5'(1 << k);
      wait_sys(PMSS_SYS_RESET);
      {external_reset_pin_n, lp_cmp_event, rtc_alarm, watchdog_wake,
       wakeup_pin} <= 5'h10;
      wait_sys(PMSS_SYS_RUN);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge ref_clk);
    t_modes;
    t_cpu;
    t_deep;
    t_warn;
    t_fault;
    t_hib;
    end_of_test;
  end
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    end_of_test;
  end
endmodule
